// file: core/dplcr_regs.sv
// Dual PLL loop configuration register bank with field decode
`timescale 1ns/1ps
module dplcr_regs (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic softReset,
  output logic [7:0] rdData,
  output logic stage1PumpPowerdown,
  output logic stage1PumpSinkEnable,
  output logic stage1PumpDouble,
  output logic [3:0] stage1PumpGain,
  output logic [8:0] stage1PumpCurrent,
  output logic stage1VctrlPolarity,
  output logic stage1ForceMidVoltage,
  output logic [5:0] stage1PumpOffset,
  output logic [5:0] stage1OffsetCurrent,
  output logic stage2InputDoubler,
  output logic [6:0] stage2PredivRatio,
  output logic stage1FbHalveSelect,
  output logic extOscHalveSelect,
  output logic [1:0] outputSourceSelect,
  output logic stage1Bypass,
  output logic stage2PumpPowerdown,
  output logic stage2PumpSinkEnable,
  output logic stage2PumpDouble,
  output logic [3:0] stage2PumpGain,
  output logic [8:0] stage2PumpCurrent,
  output logic [5:0] stage2PumpOffset,
  output logic [5:0] stage2OffsetCurrent,
  output logic [9:0] stage2FbDivRatio,
  output logic stage2FbDivPowerdown
);

  // ----------------------------------------
  // Register storage, one entry per register
  // ----------------------------------------
  localparam int NREG = 8;
  localparam logic [7:0] OFS [NREG] = '{
    dplcr_pkg::STAGE1_PUMP_CTRL_OFS, dplcr_pkg::STAGE1_PUMP_OFFSET_POLARITY_OFS,
    dplcr_pkg::STAGE2_INPUT_PREDIV_OFS, dplcr_pkg::STAGE2_SOURCE_BYPASS_OFS,
    dplcr_pkg::STAGE2_PUMP_CTRL_OFS, dplcr_pkg::STAGE2_PUMP_OFFSET_OFS,
    dplcr_pkg::STAGE2_FB_DIV_LOW_OFS, dplcr_pkg::STAGE2_FB_DIV_HIGH_OFS};
  localparam logic [7:0] MSK [NREG] = '{
    dplcr_pkg::PUMP_CTRL_MASK, dplcr_pkg::STAGE1_OFS_POL_MASK,
    dplcr_pkg::PREDIV_MASK, dplcr_pkg::SOURCE_BYPASS_MASK,
    dplcr_pkg::PUMP_CTRL_MASK, dplcr_pkg::PUMP_OFFSET_MASK,
    dplcr_pkg::FB_DIV_LOW_MASK, dplcr_pkg::FB_DIV_HIGH_MASK};
  localparam logic [7:0] RST [NREG] = '{
    dplcr_pkg::PUMP_CTRL_RST, dplcr_pkg::STAGE1_OFS_POL_RST,
    dplcr_pkg::PREDIV_RST, dplcr_pkg::SOURCE_BYPASS_RST,
    dplcr_pkg::PUMP_CTRL_RST, dplcr_pkg::PUMP_OFFSET_RST,
    dplcr_pkg::FB_DIV_LOW_RST, dplcr_pkg::FB_DIV_HIGH_RST};

  logic [7:0] regs [NREG];

  // All stored offsets sit at 0x02 or above, so soft reset covers them all
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          regs[gi] <= RST[gi];
        end else if (softReset && (OFS[gi] >= dplcr_pkg::SOFT_RESET_FIRST_OFS)) begin
          regs[gi] <= RST[gi];
        end else if (wrEn && (addr == OFS[gi])) begin
          regs[gi] <= wrData & MSK[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [7:0] next_rdData;
  always_comb begin
    next_rdData = 8'h00;
    for (int i = 0; i < NREG; i++) begin
      if (addr == OFS[i]) begin
        next_rdData = regs[i];
      end
    end
  end

  // Unmapped addresses read zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdData <= 8'h00;
    end else if (rdEn) begin
      rdData <= next_rdData;
    end
  end

  // ----------------------------------------
  // Pump current decode, units of 12.5 uA
  // ----------------------------------------
  function automatic logic [8:0] pumpCurrent(input logic dbl, input logic [3:0] g);
    logic [8:0] c;
    if (dbl) begin
      c = dplcr_pkg::DOUBLE_BASE_UNITS + 9'({g[2:0], 1'b0}) * dplcr_pkg::GAIN_STEP_UNITS;
    end else begin
      c = 9'(g) * dplcr_pkg::GAIN_STEP_UNITS;
    end
    return c;
  endfunction : pumpCurrent

  // Weights 16,8,8,4,2,1 of 12.5 uA; max 39 units = 487.5 uA
  function automatic logic [5:0] offsetCurrent(input logic [5:0] o);
    logic [5:0] c;
    c = 6'({o[5], 4'h0}) + 6'({o[4], 3'h0}) + 6'({o[3], 3'h0})
      + 6'({o[2], 2'h0}) + 6'({o[1], 1'b0}) + 6'(o[0]);
    return c;
  endfunction : offsetCurrent

  // ----------------------------------------
  // Field outputs, registered from storage
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stage1PumpPowerdown <= dplcr_pkg::PUMP_CTRL_RST[dplcr_pkg::PD_BIT];
      stage1PumpSinkEnable <= dplcr_pkg::PUMP_CTRL_RST[dplcr_pkg::SINK_BIT];
      stage1PumpDouble <= dplcr_pkg::PUMP_CTRL_RST[dplcr_pkg::DOUBLE_BIT];
      stage1PumpGain <= dplcr_pkg::PUMP_CTRL_RST[3:0];
      stage1PumpCurrent <= dplcr_pkg::DOUBLE_BASE_UNITS;
      stage1VctrlPolarity <= dplcr_pkg::STAGE1_OFS_POL_RST[dplcr_pkg::POL_BIT];
      stage1ForceMidVoltage <= dplcr_pkg::STAGE1_OFS_POL_RST[dplcr_pkg::FORCE_BIT];
      stage1PumpOffset <= dplcr_pkg::STAGE1_OFS_POL_RST[5:0];
      stage1OffsetCurrent <= 6'h00;
    end else begin
      stage1PumpPowerdown <= regs[0][dplcr_pkg::PD_BIT];
      stage1PumpSinkEnable <= regs[0][dplcr_pkg::SINK_BIT];
      stage1PumpDouble <= regs[0][dplcr_pkg::DOUBLE_BIT];
      stage1PumpGain <= regs[0][3:0];
      stage1PumpCurrent <= pumpCurrent(regs[0][dplcr_pkg::DOUBLE_BIT], regs[0][3:0]);
      stage1VctrlPolarity <= regs[1][dplcr_pkg::POL_BIT];
      stage1ForceMidVoltage <= regs[1][dplcr_pkg::FORCE_BIT];
      stage1PumpOffset <= regs[1][5:0];
      stage1OffsetCurrent <= offsetCurrent(regs[1][5:0]);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stage2InputDoubler <= dplcr_pkg::PREDIV_RST[dplcr_pkg::DOUBLER_BIT];
      stage2PredivRatio <= dplcr_pkg::PREDIV_RST[6:0];
      stage1FbHalveSelect <= dplcr_pkg::SOURCE_BYPASS_RST[dplcr_pkg::FB_HALVE_BIT];
      extOscHalveSelect <= dplcr_pkg::SOURCE_BYPASS_RST[dplcr_pkg::EXT_HALVE_BIT];
      outputSourceSelect <= dplcr_pkg::SOURCE_BYPASS_RST[dplcr_pkg::SRC_LSB +: 2];
      stage1Bypass <= dplcr_pkg::SOURCE_BYPASS_RST[dplcr_pkg::BYPASS_BIT];
    end else begin
      stage2InputDoubler <= regs[2][dplcr_pkg::DOUBLER_BIT];
      stage2PredivRatio <= regs[2][6:0];
      stage1FbHalveSelect <= regs[3][dplcr_pkg::FB_HALVE_BIT];
      extOscHalveSelect <= regs[3][dplcr_pkg::EXT_HALVE_BIT];
      outputSourceSelect <= regs[3][dplcr_pkg::SRC_LSB +: 2];
      stage1Bypass <= regs[3][dplcr_pkg::BYPASS_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stage2PumpPowerdown <= dplcr_pkg::PUMP_CTRL_RST[dplcr_pkg::PD_BIT];
      stage2PumpSinkEnable <= dplcr_pkg::PUMP_CTRL_RST[dplcr_pkg::SINK_BIT];
      stage2PumpDouble <= dplcr_pkg::PUMP_CTRL_RST[dplcr_pkg::DOUBLE_BIT];
      stage2PumpGain <= dplcr_pkg::PUMP_CTRL_RST[3:0];
      stage2PumpCurrent <= dplcr_pkg::DOUBLE_BASE_UNITS;
      stage2PumpOffset <= dplcr_pkg::PUMP_OFFSET_RST[5:0];
      stage2OffsetCurrent <= 6'h00;
      stage2FbDivRatio <= {dplcr_pkg::FB_DIV_HIGH_RST[1:0], dplcr_pkg::FB_DIV_LOW_RST};
      stage2FbDivPowerdown <= dplcr_pkg::FB_DIV_HIGH_RST[dplcr_pkg::PD_BIT];
    end else begin
      stage2PumpPowerdown <= regs[4][dplcr_pkg::PD_BIT];
      stage2PumpSinkEnable <= regs[4][dplcr_pkg::SINK_BIT];
      stage2PumpDouble <= regs[4][dplcr_pkg::DOUBLE_BIT];
      stage2PumpGain <= regs[4][3:0];
      stage2PumpCurrent <= pumpCurrent(regs[4][dplcr_pkg::DOUBLE_BIT], regs[4][3:0]);
      stage2PumpOffset <= regs[5][5:0];
      stage2OffsetCurrent <= offsetCurrent(regs[5][5:0]);
      stage2FbDivRatio <= {regs[7][1:0], regs[6]};
      stage2FbDivPowerdown <= regs[7][dplcr_pkg::PD_BIT];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_pd1;
    @(posedge ref_clk) disable iff (!nrst)
    (wrEn && !softReset && addr == 8'h1C) |=> ##1 (stage1PumpPowerdown == $past(wrData[7], 2));
  endproperty
  a_pd1: assert property (p_pd1) else $error("Stage-1 powerdown mismatch");

  property p_cur;
    @(posedge ref_clk) disable iff (!nrst)
    (wrEn && !softReset && addr == 8'h1C && wrData[4])
      |=> ##1 (stage1PumpCurrent == 9'h080 + 9'({$past(wrData[2:0], 2), 4'h0}));
  endproperty
  a_cur: assert property (p_cur) else $error("Doubled pump current wrong");

  property p_cur1;
    @(posedge ref_clk) disable iff (!nrst)
    (wrEn && !softReset && addr == 8'h1C && !wrData[4])
      |=> ##1 (stage1PumpCurrent == 9'({$past(wrData[3:0], 2), 3'h0}));
  endproperty
  a_cur1: assert property (p_cur1) else $error("Single pump current wrong");

  property p_ofs;
    @(posedge ref_clk) disable iff (!nrst)
    (wrEn && !softReset && addr == 8'h1D && wrData[5:0] == 6'h3F)
      |=> ##1 (stage1OffsetCurrent == 6'h27);
  endproperty
  a_ofs: assert property (p_ofs) else $error("Offset current full scale wrong");

  property p_srst;
    @(posedge ref_clk) disable iff (!nrst)
    softReset |=> ##1 (stage1ForceMidVoltage && stage2FbDivRatio == 10'h020
      && stage2PredivRatio == 7'h01 && outputSourceSelect == 2'h1);
  endproperty
  a_srst: assert property (p_srst) else $error("Soft reset defaults wrong");

  property p_rsv;
    @(posedge ref_clk) disable iff (!nrst)
    (rdEn && addr == 8'h29) |=> (rdData[7:6] == 2'h0);
  endproperty
  a_rsv: assert property (p_rsv) else $error("Reserved bits read nonzero");

  property p_div;
    @(posedge ref_clk) disable iff (!nrst)
    (wrEn && !softReset && addr == 8'h2C) |=> ##1 (stage2FbDivRatio[7:0] == $past(wrData, 2));
  endproperty
  a_div: assert property (p_div) else $error("Feedback divider low byte wrong");

  property p_src;
    @(posedge ref_clk) disable iff (!nrst)
    (wrEn && !softReset && addr == 8'h21)
      |=> ##1 (outputSourceSelect == $past(wrData[5:4], 2)
      && stage1Bypass == $past(wrData[3], 2));
  endproperty
  a_src: assert property (p_src) else $error("Source select or bypass wrong");

  property p_sink1;
    @(posedge ref_clk) disable iff (!nrst)
    (wrEn && !softReset && addr == dplcr_pkg::STAGE1_PUMP_CTRL_OFS)
      |=> ##1 (stage1PumpSinkEnable == $past(wrData[5], 2));
  endproperty
  a_sink1: assert property (p_sink1) else $error("Stage-1 sink enable mismatch");

  property p_dbl1;
    @(posedge ref_clk) disable iff (!nrst)
    (wrEn && !softReset && addr == dplcr_pkg::STAGE1_PUMP_CTRL_OFS)
      |=> ##1 (stage1PumpDouble == $past(wrData[4], 2));
  endproperty
  a_dbl1: assert property (p_dbl1) else $error("Stage-1 doubling mismatch");

  property p_pol;
    @(posedge ref_clk) disable iff (!nrst)
    (wrEn && !softReset && addr == dplcr_pkg::STAGE1_PUMP_OFFSET_POLARITY_OFS)
      |=> ##1 (stage1VctrlPolarity == $past(wrData[7], 2));
  endproperty
  a_pol: assert property (p_pol) else $error("Control voltage polarity mismatch");

  property p_force;
    @(posedge ref_clk) disable iff (!nrst)
    (wrEn && !softReset && addr == dplcr_pkg::STAGE1_PUMP_OFFSET_POLARITY_OFS)
      |=> ##1 (stage1ForceMidVoltage == $past(wrData[6], 2));
  endproperty
  a_force: assert property (p_force) else $error("Force mid voltage mismatch");

  property p_dblr;
    @(posedge ref_clk) disable iff (!nrst)
    (wrEn && !softReset && addr == dplcr_pkg::STAGE2_INPUT_PREDIV_OFS)
      |=> ##1 (stage2InputDoubler == $past(wrData[7], 2));
  endproperty
  a_dblr: assert property (p_dblr) else $error("Input doubler mismatch");

  property p_prediv;
    @(posedge ref_clk) disable iff (!nrst)
    (wrEn && !softReset && addr == dplcr_pkg::STAGE2_INPUT_PREDIV_OFS)
      |=> ##1 (stage2PredivRatio == $past(wrData[6:0], 2));
  endproperty
  a_prediv: assert property (p_prediv) else $error("Predivider ratio mismatch");

  property p_fbhalve;
    @(posedge ref_clk) disable iff (!nrst)
    (wrEn && !softReset && addr == dplcr_pkg::STAGE2_SOURCE_BYPASS_OFS)
      |=> ##1 (stage1FbHalveSelect == $past(wrData[7], 2));
  endproperty
  a_fbhalve: assert property (p_fbhalve) else $error("Feedback halve mismatch");

  property p_exthalve;
    @(posedge ref_clk) disable iff (!nrst)
    (wrEn && !softReset && addr == dplcr_pkg::STAGE2_SOURCE_BYPASS_OFS)
      |=> ##1 (extOscHalveSelect == $past(wrData[6], 2));
  endproperty
  a_exthalve: assert property (p_exthalve) else $error("Oscillator halve mismatch");

  property p_pump2;
    @(posedge ref_clk) disable iff (!nrst)
    (wrEn && !softReset && addr == dplcr_pkg::STAGE2_PUMP_CTRL_OFS)
      |=> ##1 (stage2PumpPowerdown == $past(wrData[7], 2)
      && stage2PumpSinkEnable == $past(wrData[5], 2)
      && stage2PumpDouble == $past(wrData[4], 2) && stage2PumpGain == $past(wrData[3:0], 2));
  endproperty
  a_pump2: assert property (p_pump2) else $error("Stage-2 pump fields mismatch");

  property p_cur2;
    @(posedge ref_clk) disable iff (!nrst)
    (wrEn && !softReset && addr == dplcr_pkg::STAGE2_PUMP_CTRL_OFS && wrData[4])
      |=> ##1 (stage2PumpCurrent == 9'h080 + 9'({$past(wrData[2:0], 2), 4'h0}));
  endproperty
  a_cur2: assert property (p_cur2) else $error("Stage-2 doubled current wrong");

  property p_ofs2;
    @(posedge ref_clk) disable iff (!nrst)
    (wrEn && !softReset && addr == dplcr_pkg::STAGE2_PUMP_OFFSET_OFS)
      |=> ##1 (stage2PumpOffset == $past(wrData[5:0], 2));
  endproperty
  a_ofs2: assert property (p_ofs2) else $error("Stage-2 offset field mismatch");

  property p_divhi;
    @(posedge ref_clk) disable iff (!nrst)
    (wrEn && !softReset && addr == dplcr_pkg::STAGE2_FB_DIV_HIGH_OFS)
      |=> ##1 (stage2FbDivRatio[9:8] == $past(wrData[1:0], 2));
  endproperty
  a_divhi: assert property (p_divhi) else $error("Feedback divider high bits wrong");

  property p_pd2;
    @(posedge ref_clk) disable iff (!nrst)
    (wrEn && !softReset && addr == dplcr_pkg::STAGE2_FB_DIV_HIGH_OFS)
      |=> ##1 (stage2FbDivPowerdown == $past(wrData[7], 2));
  endproperty
  a_pd2: assert property (p_pd2) else $error("Divider powerdown mismatch");

  property p_srst2;
    @(posedge ref_clk) disable iff (!nrst)
    softReset |=> ##1 (stage1PumpCurrent == dplcr_pkg::DOUBLE_BASE_UNITS
      && stage2PumpCurrent == dplcr_pkg::DOUBLE_BASE_UNITS && stage1OffsetCurrent == 6'h00);
  endproperty
  a_srst2: assert property (p_srst2) else $error("Soft reset currents wrong");

endmodule : dplcr_regs

// file: core/dplcr_pkg.sv
// Package for the dual PLL loop configuration register bank
package dplcr_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] STAGE1_PUMP_CTRL_OFS = 8'h1C;
  localparam logic [7:0] STAGE1_PUMP_OFFSET_POLARITY_OFS = 8'h1D;
  localparam logic [7:0] STAGE2_INPUT_PREDIV_OFS = 8'h20;
  localparam logic [7:0] STAGE2_SOURCE_BYPASS_OFS = 8'h21;
  localparam logic [7:0] STAGE2_PUMP_CTRL_OFS = 8'h28;
  localparam logic [7:0] STAGE2_PUMP_OFFSET_OFS = 8'h29;
  localparam logic [7:0] STAGE2_FB_DIV_LOW_OFS = 8'h2C;
  localparam logic [7:0] STAGE2_FB_DIV_HIGH_OFS = 8'h2D;
  localparam logic [7:0] SOFT_RESET_FIRST_OFS = 8'h02;

  // ----------------------------------------
  // Writable bit masks (reserved bits clear)
  // ----------------------------------------
  localparam logic [7:0] PUMP_CTRL_MASK = 8'hBF;
  localparam logic [7:0] STAGE1_OFS_POL_MASK = 8'hFF;
  localparam logic [7:0] PREDIV_MASK = 8'hFF;
  localparam logic [7:0] SOURCE_BYPASS_MASK = 8'hF8;
  localparam logic [7:0] PUMP_OFFSET_MASK = 8'h3F;
  localparam logic [7:0] FB_DIV_LOW_MASK = 8'hFF;
  localparam logic [7:0] FB_DIV_HIGH_MASK = 8'h83;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] PUMP_CTRL_RST = 8'h30;
  localparam logic [7:0] STAGE1_OFS_POL_RST = 8'h40;
  localparam logic [7:0] PREDIV_RST = 8'h01;
  localparam logic [7:0] SOURCE_BYPASS_RST = 8'h90;
  localparam logic [7:0] PUMP_OFFSET_RST = 8'h00;
  localparam logic [7:0] FB_DIV_LOW_RST = 8'h20;
  localparam logic [7:0] FB_DIV_HIGH_RST = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PD_BIT = 7;
  localparam int SINK_BIT = 5;
  localparam int DOUBLE_BIT = 4;
  localparam int POL_BIT = 7;
  localparam int FORCE_BIT = 6;
  localparam int DOUBLER_BIT = 7;
  localparam int FB_HALVE_BIT = 7;
  localparam int EXT_HALVE_BIT = 6;
  localparam int SRC_LSB = 4;
  localparam int BYPASS_BIT = 3;

  // ----------------------------------------
  // Current weights in units of 12.5 uA
  // ----------------------------------------
  localparam logic [8:0] GAIN_STEP_UNITS = 9'h008;
  localparam logic [8:0] DOUBLE_BASE_UNITS = 9'h080;

endpackage : dplcr_pkg

// file: testbench/dplcr_host.sv
// Host model that drives the register bank access strobes
`timescale 1ns/1ps
module dplcr_host (
  input wire logic ref_clk,
  input wire logic [7:0] rdData,
  output logic wrEn,
  output logic rdEn,
  output logic [7:0] addr,
  output logic [7:0] wrData,
  output logic softReset
);
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  initial begin
    wrEn = 1'b0;
    rdEn = 1'b0;
    softReset = 1'b0;
    addr = 8'h00;
    wrData = 8'h00;
  end

  // Strobes move only at falling edges so the rising edge sees them settled
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    addr = a;
    wrData = d;
    wrEn = 1'b1;
    @(negedge ref_clk);
    wrEn = 1'b0;
  endtask : wr_reg

  // Data is taken one full cycle after the strobe edge
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    addr = a;
    rdEn = 1'b1;
    @(negedge ref_clk);
    rdEn = 1'b0;
    @(negedge ref_clk);
    d = rdData;
  endtask : rd_reg

  task automatic soft_rst();
    @(negedge ref_clk);
    softReset = 1'b1;
    @(negedge ref_clk);
    softReset = 1'b0;
  endtask : soft_rst
endmodule : dplcr_host

// file: testbench/dplcr_regs_test.sv
// Self-checking testbench for the dual PLL loop register bank
`timescale 1ns/1ps
module dplcr_regs_test;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic wrEn, rdEn, softReset;
  logic [7:0] addr, wrData, rdData, rd;
  logic [8:0] cur1, cur2;
  logic [5:0] ofs1, ofs2;
  logic [9:0] fbDiv;
  wire [7:0] img [8];
  int failCount = 0;
  int testsRun = 0;
  logic [7:0] addrs [8] = '{8'h1C, 8'h1D, 8'h20, 8'h21, 8'h28, 8'h29, 8'h2C, 8'h2D};
  logic [7:0] rsts [8] = '{8'h30, 8'h40, 8'h01, 8'h90, 8'h30, 8'h00, 8'h20, 8'h00};
  logic [7:0] masks [8] = '{8'hBF, 8'hFF, 8'hFF, 8'hF8, 8'hBF, 8'h3F, 8'hFF, 8'h83};
  logic [5:0] ofsW [6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h08, 6'h10};

  always #12.5 ref_clk = ~ref_clk;

  dplcr_host host (.ref_clk(ref_clk), .rdData(rdData), .wrEn(wrEn), .rdEn(rdEn),
    .addr(addr), .wrData(wrData), .softReset(softReset));

  dplcr_regs DUT (.ref_clk(ref_clk), .nrst(nrst), .wrEn(wrEn), .rdEn(rdEn), .addr(addr),
    .wrData(wrData), .softReset(softReset), .rdData(rdData),
    .stage1PumpPowerdown(img[0][7]), .stage1PumpSinkEnable(img[0][5]),
    .stage1PumpDouble(img[0][4]), .stage1PumpGain(img[0][3:0]), .stage1PumpCurrent(cur1),
    .stage1VctrlPolarity(img[1][7]), .stage1ForceMidVoltage(img[1][6]),
    .stage1PumpOffset(img[1][5:0]), .stage1OffsetCurrent(ofs1),
    .stage2InputDoubler(img[2][7]), .stage2PredivRatio(img[2][6:0]),
    .stage1FbHalveSelect(img[3][7]), .extOscHalveSelect(img[3][6]),
    .outputSourceSelect(img[3][5:4]), .stage1Bypass(img[3][3]),
    .stage2PumpPowerdown(img[4][7]), .stage2PumpSinkEnable(img[4][5]),
    .stage2PumpDouble(img[4][4]), .stage2PumpGain(img[4][3:0]), .stage2PumpCurrent(cur2),
    .stage2PumpOffset(img[5][5:0]), .stage2OffsetCurrent(ofs2),
    .stage2FbDivRatio(fbDiv), .stage2FbDivPowerdown(img[7][7]));

  // Field outputs folded back into register images, reserved bits zero
  assign img[0][6] = 1'b0;
  assign img[3][2:0] = 3'h0;
  assign img[4][6] = 1'b0;
  assign img[5][7:6] = 2'h0;
  assign img[6] = fbDiv[7:0];
  assign img[7][6:0] = {5'h00, fbDiv[9:8]};

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic completeRun();
    $display("checks %0d mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : completeRun

  // Every mapped offset against its default byte
  task automatic resetCheck();
    for (int i = 0; i < 8; i++) begin
      host.rd_reg(addrs[i], rd);
      check("default", {8'h00, rd}, {8'h00, rsts[i]});
      check("field default", {8'h00, img[i]}, {8'h00, rsts[i]});
    end
    check("pump current", {7'h00, cur1}, 16'h0080);
    check("fb divider", {6'h00, fbDiv}, 16'h0020);
    check("source", {14'h0000, img[3][5:4]}, 16'h0001);
    check("bypass", {15'h0000, img[3][3]}, 16'h0000);
  endtask : resetCheck

  // Sized for 4000 cycles of traffic, far beyond the run of a few hundred
  initial begin
    #100000;
    failCount++;
    completeRun();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (3) @(negedge ref_clk);
    nrst = 1'b1;
    resetCheck();
    host.rd_reg(8'h30, rd);
    check("unmapped", {8'h00, rd}, 16'h0000);
    $display("test defaults done");
    for (int i = 0; i < 8; i++) begin
      host.wr_reg(addrs[i], 8'hFF);
      host.rd_reg(addrs[i], rd);
      check("masked", {8'h00, rd}, {8'h00, masks[i]});
    end
    check("pump1 max", {7'h00, cur1}, 16'h00F0);
    check("pump2 max", {7'h00, cur2}, 16'h00F0);
    check("offset1 max", {10'h000, ofs1}, 16'h0027);
    check("offset2 max", {10'h000, ofs2}, 16'h0027);
    check("fb max", {6'h00, fbDiv}, 16'h03FF);
    check("source", {14'h0000, img[3][5:4]}, 16'h0003);
    check("bypass", {15'h0000, img[3][3]}, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      check("field max", {8'h00, img[i]}, {8'h00, masks[i]});
    end
    $display("test masks done");
    for (int g = 0; g < 32; g++) begin
      host.wr_reg(8'h1C, {3'b000, g[4:0]});
      repeat (2) @(negedge ref_clk);
      // Top gain bit must drop out when doubled
      check("gain", {7'h00, cur1}, g[4] ? 16'd128 + 16'(g[2:0]) * 16 : 16'(g[3:0]) * 8);
    end
    $display("test gain done");
    for (int b = 0; b < 6; b++) begin
      host.wr_reg(8'h1D, 8'h01 << b);
      repeat (2) @(negedge ref_clk);
      check("force", {15'h0000, img[1][6]}, 16'h0000);
      check("offset", {10'h000, ofs1}, {10'h000, ofsW[b]});
    end
    $display("test offset done");
    host.wr_reg(8'h21, 8'hC0);
    host.soft_rst();
    repeat (2) @(negedge ref_clk);
    resetCheck();
    $display("test soft reset done");
    host.wr_reg(8'h2D, 8'h83);
    @(negedge ref_clk);
    nrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    resetCheck();
    $display("test async reset done");
    completeRun();
  end
endmodule : dplcr_regs_test
